// ===== bench/gph_pin_model.sv
// Outside pin levels seen by ports G and H.
`timescale 1ns/1ps
module gph_pin_model (
   // Design drive.
   input wire logic [4:0] g_pin_out,
   input wire logic [4:0] g_pin_oe,
   input wire logic [7:0] h_pin_out,
   input wire logic [7:0] h_pin_oe,
   // Outside levels.
   input wire logic [5:0] g_drive,
   input wire logic [7:0] h_drive,
   // Resolved levels.
   output logic [5:0] g_pin_in,
   output logic [7:0] h_pin_in
);
   // A driven pin shows the design's level; the sixth pin is never driven.
   assign g_pin_in = {g_drive[5], (g_pin_oe & g_pin_out) | (~g_pin_oe & g_drive[4:0])};
   assign h_pin_in = (h_pin_oe & h_pin_out) | (~h_pin_oe & h_drive);
endmodule : gph_pin_model

// ===== bench/tb.sv
// Self-checking bench for the port G and H block.
`timescale 1ns/1ps
`include "gph_params.svh"
module tb;
   logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, err;
   logic pready, pslverr, mci, acd, uba;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, v, d;
   logic [7:0] cfg = '0, h_out, h_oe, h_in, h_drv = '0, e_hoe, e_hout, e_hrd;
   logic [5:0] g_in, g_drv = '0;
   logic [4:0] g_out, g_oe, p_oe = '0, p_val = '0, p_in = '0, e_oe, e_out;
   logic [3:0] a_hi = '0;
   int n_fail = 0, n_compared = 0, cycles = 0, seed = 17;
   always #50 pclk = ~pclk;
   gph_ports DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .config_byte_three_high(cfg), .g_pin_in(g_in), .g_pin_out(g_out),
      .g_pin_oe(g_oe), .master_clear_input(mci), .g_periph_out_en(p_oe),
      .g_periph_out_val(p_val), .g_periph_in_force(p_in), .h_pin_in(h_in),
      .h_pin_out(h_out), .h_pin_oe(h_oe), .upper_address_bits(a_hi),
      .analog_channels_digital(acd), .upper_address_bus_active(uba));
   gph_pin_model PINS (.g_pin_out(g_out), .g_pin_oe(g_oe), .h_pin_out(h_out),
      .h_pin_oe(h_oe), .g_drive(g_drv), .h_drive(h_drv), .g_pin_in(g_in), .h_pin_in(h_in));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 100);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, '0);
      check(rd, exp);
   endtask : rdchk
   task automatic conclude();
      $display("Compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         conclude();
      end
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      {h_drv, a_hi} <= $random(seed);
      rdchk(`GPH_OFF_G_DIR, 32'h1F);
      rdchk(`GPH_OFF_H_DIR, 32'hFF);
      rdchk(`GPH_OFF_H_PIN, 32'h0);
      check({acd, uba}, 2'h1);
      check({h_oe[3:0], h_out[3:0]}, {4'hF, a_hi});
      for (int i = 0; i < 12; i++) begin
         v = $random(seed);
         d = $random(seed);
         {cfg, g_drv, p_oe, p_val, p_in} <= $random(seed);
         apb(1'b1, `GPH_OFF_G_PIN, v);
         apb(1'b1, `GPH_OFF_G_DIR, d);
         e_oe = (~d[4:0] | p_oe) & ~p_in;
         e_out = (p_oe & p_val) | (~p_oe & v[4:0]);
         repeat (3) @(posedge pclk);
         check(g_oe, e_oe);
         check(g_out & e_oe, e_out & e_oe);
         check(mci, cfg[7] & ~g_drv[5]);
         rdchk(`GPH_OFF_G_LAT, v[4:0]);
         rdchk(`GPH_OFF_G_DIR, d[4:0]);
         d = {~cfg[7] & g_drv[5], (e_oe & e_out) | (~e_oe & g_drv[4:0])};
         rdchk(`GPH_OFF_G_PIN, d);
      end
      for (int m = 0; m < 4; m++) begin
         v = $random(seed);
         d = $random(seed);
         apb(1'b1, `GPH_OFF_MUX, 32'(m));
         apb(1'b1, `GPH_OFF_H_PIN, v);
         apb(1'b1, `GPH_OFF_H_DIR, d);
         e_hoe = m[1] ? ~d[7:0] : {~d[7:4], 4'hF};
         e_hout = m[1] ? v[7:0] : {v[7:4], a_hi};
         e_hrd = ((e_hoe & e_hout) | (~e_hoe & h_drv)) & {{4{m[0]}}, {4{m[1]}}};
         e_hoe = e_hoe & {{4{m[0]}}, 4'hF};
         repeat (3) @(posedge pclk);
         check({h_oe & {{4{m[0]}}, 4'hF}, acd, uba}, {e_hoe, m[0], ~m[1]});
         check(h_out & e_hoe, e_hout & e_hoe);
         rdchk(`GPH_OFF_H_LAT, v[7:0]);
         rdchk(`GPH_OFF_H_PIN, e_hrd);
      end
      apb(1'b0, 12'h01C, '0);
      check(err, 1'b1);
      conclude();
   end
endmodule : tb

// ===== logic/gph_params.svh
// Register offsets, field positions and reset values for the port G/H block.
`ifndef GPH_PARAMS_SVH
`define GPH_PARAMS_SVH
`define GPH_OFF_G_PIN 12'h000
`define GPH_OFF_G_LAT 12'h004
`define GPH_OFF_G_DIR 12'h008
`define GPH_OFF_H_PIN 12'h00C
`define GPH_OFF_H_LAT 12'h010
`define GPH_OFF_H_DIR 12'h014
`define GPH_OFF_MUX 12'h018
`define GPH_G_DIR_RST 5'h1F
`define GPH_H_DIR_RST 8'hFF
`define GPH_LAT_RST 8'h00
`define GPH_MUX_RST 2'h0
`define GPH_MUX_ANA_DIG_BIT 0
`define GPH_MUX_BUS_DIS_BIT 1
`define GPH_G_IN_ONLY_BIT 5
`define GPH_MASTER_CLEAR_ENABLE_CFG_BIT 7
`endif

// ===== logic/gph_pkg.sv
// Types shared by the port G/H block.
package gph_pkg;
   typedef struct packed {
      logic [4:0] g_dir;
      logic [4:0] g_lat;
      logic [7:0] h_dir;
      logic [7:0] h_lat;
      logic [1:0] mux;
      logic [5:0] g_s1;
      logic [5:0] g_s2;
      logic [7:0] h_s1;
      logic [7:0] h_s2;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [4:0] g_out;
      logic [4:0] g_oe;
      logic [7:0] h_out;
      logic [7:0] h_oe;
      logic master_clear_input_req;
   } gph_state_type;
endpackage : gph_pkg

// ===== logic/gph_ports.sv
// Port G and port H general-purpose I/O with an APB register slave.
//
// How it works
// - Port G: five two-way pins, one input-only.
// - Direction one tristates, zero drives latch.
// - Latch register reads back latched output value.
// - Enabled peripherals force pin output or input.
// - Overrides never alter the stored direction bits.
// - Port G pins reset as digital inputs.
// - Sixth pin is master clear when enabled.
// - Sixth pin has no direction or latch.
// - Sixth pin readable at bit five only if disabled.
// - Sixth pin also takes programming voltage always.
// - Port G carries capture channels and serial two.
// - Port H: eight two-way pins, own registers.
// - Upper H pins shared with analog channels.
// - Lower H pins shared with upper address bits.
// - Upper H pins reset analog, read zero.
// - Lower H pins reset driving address bus.
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "gph_params.svh"
module gph_ports
   import gph_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Configuration byte inputs.
   input wire logic [7:0] config_byte_three_high,
   // Port G pins.
   input wire logic [5:0] g_pin_in,
   output logic [4:0] g_pin_out,
   output logic [4:0] g_pin_oe,
   output logic master_clear_input,
   // Port G peripheral overrides: bit0 capture 3, 1 serial tx/clk, 2 serial rx/data, 3..4 cap 4/5.
   input wire logic [4:0] g_periph_out_en,
   input wire logic [4:0] g_periph_out_val,
   input wire logic [4:0] g_periph_in_force,
   // Port H pins.
   input wire logic [7:0] h_pin_in,
   output logic [7:0] h_pin_out,
   output logic [7:0] h_pin_oe,
   // Port H upper address bits from the memory interface.
   input wire logic [3:0] upper_address_bits,
   output logic analog_channels_digital,
   output logic upper_address_bus_active
);

   gph_state_type st_ff;
   gph_state_type nxt_st;

   // ==========================================================================
   // Register update and pin paths.
   always_comb begin
      logic acc;
      logic wr;
      logic master_clear_enable_cfg;
      logic [7:0] g_rd;
      logic [7:0] h_rd;
      logic ana_dig;
      logic bus_dis;
      acc = psel && penable;
      // A write lands only at the edge where pready is sampled high.
      wr = acc && pwrite && st_ff.pready;
      master_clear_enable_cfg = config_byte_three_high[`GPH_MASTER_CLEAR_ENABLE_CFG_BIT];
      ana_dig = st_ff.mux[`GPH_MUX_ANA_DIG_BIT];
      bus_dis = st_ff.mux[`GPH_MUX_BUS_DIS_BIT];
      nxt_st = st_ff;
      nxt_st.g_s1 = g_pin_in;
      nxt_st.g_s2 = st_ff.g_s1;
      nxt_st.h_s1 = h_pin_in;
      nxt_st.h_s2 = st_ff.h_s1;
      // Pin read value of port G; sixth bit only when master clear is off.
      g_rd = {2'h0, st_ff.g_s2};
      g_rd[`GPH_G_IN_ONLY_BIT] = st_ff.g_s2[`GPH_G_IN_ONLY_BIT] & ~master_clear_enable_cfg;
      // Port H reads zero on analog pins and bus-owned pins.
      h_rd = st_ff.h_s2;
      if (!ana_dig) begin
         h_rd[7:4] = 4'h0;
      end
      if (!bus_dis) begin
         h_rd[3:0] = 4'h0;
      end
      nxt_st.pready = acc && !st_ff.pready;
      nxt_st.pslverr = 1'b0;
      nxt_st.prdata = 32'h0000_0000;
      if (acc) begin
         unique case (paddr)
            `GPH_OFF_G_PIN: begin
               nxt_st.prdata = {24'h0, g_rd};
               if (wr) begin
                  nxt_st.g_lat = pwdata[4:0];
               end
            end
            `GPH_OFF_G_LAT: begin
               nxt_st.prdata = {27'h0, st_ff.g_lat};
               if (wr) begin
                  nxt_st.g_lat = pwdata[4:0];
               end
            end
            `GPH_OFF_G_DIR: begin
               nxt_st.prdata = {27'h0, st_ff.g_dir};
               if (wr) begin
                  nxt_st.g_dir = pwdata[4:0];
               end
            end
            `GPH_OFF_H_PIN: begin
               nxt_st.prdata = {24'h0, h_rd};
               if (wr) begin
                  nxt_st.h_lat = pwdata[7:0];
               end
            end
            `GPH_OFF_H_LAT: begin
               nxt_st.prdata = {24'h0, st_ff.h_lat};
               if (wr) begin
                  nxt_st.h_lat = pwdata[7:0];
               end
            end
            `GPH_OFF_H_DIR: begin
               nxt_st.prdata = {24'h0, st_ff.h_dir};
               if (wr) begin
                  nxt_st.h_dir = pwdata[7:0];
               end
            end
            `GPH_OFF_MUX: begin
               nxt_st.prdata = {30'h0, st_ff.mux};
               if (wr) begin
                  nxt_st.mux = pwdata[1:0];
               end
            end
            default: begin
               nxt_st.pslverr = 1'b1;
            end
         endcase
      end
      // Read data and error stand only in the cycle that pready is high.
      if (st_ff.pready) begin
         nxt_st.prdata = 32'h0000_0000;
         nxt_st.pslverr = 1'b0;
      end
      // Port G drivers with peripheral overrides; input force wins.
      for (int i = 0; i < 5; i++) begin
         nxt_st.g_oe[i] = (g_periph_out_en[i] | ~st_ff.g_dir[i]) & ~g_periph_in_force[i];
         nxt_st.g_out[i] = g_periph_out_en[i] ? g_periph_out_val[i] : st_ff.g_lat[i];
      end
      // Port H drivers: upper pins tristate in analog mode, lower drive the address bus.
      nxt_st.h_out = st_ff.h_lat;
      nxt_st.h_oe = ~st_ff.h_dir;
      if (!ana_dig) begin
         nxt_st.h_oe[7:4] = 4'h0;
      end
      if (!bus_dis) begin
         nxt_st.h_out[3:0] = upper_address_bits;
         nxt_st.h_oe[3:0] = 4'hF;
      end
      nxt_st.master_clear_input_req = master_clear_enable_cfg & ~st_ff.g_s2[`GPH_G_IN_ONLY_BIT];
   end

   // ==========================================================================
   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
         st_ff.g_dir <= `GPH_G_DIR_RST;
         st_ff.h_dir <= `GPH_H_DIR_RST;
         st_ff.g_lat <= 5'h00;
         st_ff.h_lat <= `GPH_LAT_RST;
         st_ff.mux <= `GPH_MUX_RST;
         st_ff.g_s1 <= 6'h3F;
         st_ff.g_s2 <= 6'h3F;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================================
   // Outputs.
   assign prdata = st_ff.prdata;
   assign pready = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign g_pin_out = st_ff.g_out;
   assign g_pin_oe = st_ff.g_oe;
   assign h_pin_out = st_ff.h_out;
   assign h_pin_oe = st_ff.h_oe;
   assign master_clear_input = st_ff.master_clear_input_req;
   assign analog_channels_digital = st_ff.mux[`GPH_MUX_ANA_DIG_BIT];
   assign upper_address_bus_active = ~st_ff.mux[`GPH_MUX_BUS_DIS_BIT];

   // ==========================================================================
   // Assertions.
   a_dir_tristate: assert property (@(posedge pclk) disable iff (!presetn)
      (st_ff.g_dir[0] && !g_periph_out_en[0]) |=> !g_pin_oe[0])
      else $error("Port G pin 0 driven while direction is input.");
   a_input_force: assert property (@(posedge pclk) disable iff (!presetn)
      g_periph_in_force[2] |=> !g_pin_oe[2])
      else $error("Forced input pin still driven.");
   a_out_force: assert property (@(posedge pclk) disable iff (!presetn)
      (g_periph_out_en[1] && !g_periph_in_force[1]) |=> (g_pin_oe[1] && g_pin_out[1] == $past(g_periph_out_val[1])))
      else $error("Peripheral output override not applied.");
   a_dir_kept: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && penable && pwrite) |=> $stable(st_ff.g_dir))
      else $error("Direction bits changed without a write.");
   a_bus_drive: assert property (@(posedge pclk) disable iff (!presetn)
      !st_ff.mux[1] |=> (h_pin_oe[3:0] == 4'hF && h_pin_out[3:0] == $past(upper_address_bits)))
      else $error("Lower port H pins not driving the address bus.");
   a_analog_off: assert property (@(posedge pclk) disable iff (!presetn)
      !st_ff.mux[0] |=> h_pin_oe[7:4] == 4'h0)
      else $error("Analog port H pins driven.");
   a_master_clear_input_map: assert property (@(posedge pclk) disable iff (!presetn)
      (config_byte_three_high[7] && !st_ff.g_s2[5]) |=> master_clear_input)
      else $error("Master clear not raised.");
   a_g5_read: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready && paddr == 12'h000 && config_byte_three_high[7])
      |=> !prdata[5])
      else $error("Sixth pin readable while master clear enabled.");
   a_lat_read: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready && !pwrite && paddr == 12'h004)
      |=> prdata[4:0] == $past(st_ff.g_lat))
      else $error("Latch read does not return latched value.");
   a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("Ready held longer than one cycle.");
   a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("Error raised without ready.");
   a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !pready |-> prdata == 32'h0000_0000)
      else $error("Read data not zero outside a ready cycle.");
   a_unused_bits: assert property (@(posedge pclk) disable iff (!presetn)
      pready |-> prdata[31:8] == 24'h00_0000)
      else $error("Unused read bits not zero.");
   a_g_lat_write: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && pready && paddr == `GPH_OFF_G_LAT)
      |=> st_ff.g_lat == $past(pwdata[4:0]))
      else $error("Port G latch write not stored.");
   a_g_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && pready && paddr == `GPH_OFF_G_DIR)
      |=> st_ff.g_dir == $past(pwdata[4:0]))
      else $error("Port G direction write not stored.");
   a_h_lat_write: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && pready && paddr == `GPH_OFF_H_LAT)
      |=> st_ff.h_lat == $past(pwdata[7:0]))
      else $error("Port H latch write not stored.");
   a_mux_write: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && pready && paddr == `GPH_OFF_MUX)
      |=> st_ff.mux == $past(pwdata[1:0]))
      else $error("Pin function select write not stored.");
   a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready && paddr == `GPH_OFF_H_PIN && !st_ff.mux[0])
      |=> prdata[7:4] == 4'h0)
      else $error("Analog port H pins read nonzero.");
   a_lower_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready && paddr == `GPH_OFF_H_PIN && !st_ff.mux[1])
      |=> prdata[3:0] == 4'h0)
      else $error("Bus owned port H pins read nonzero.");
   a_force_in0: assert property (@(posedge pclk) disable iff (!presetn)
      g_periph_in_force[0] |=> !g_pin_oe[0])
      else $error("Forced input pin 0 still driven.");
   a_h_dir_tri: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.h_dir[4] |=> !h_pin_oe[4])
      else $error("Port H input pin driven.");
   a_h_drive_lat: assert property (@(posedge pclk) disable iff (!presetn)
      (!st_ff.h_dir[5] && st_ff.mux[0])
      |=> (h_pin_oe[5] && h_pin_out[5] == $past(st_ff.h_lat[5])))
      else $error("Port H output pin not driving its latch.");
   a_g_drive_lat: assert property (@(posedge pclk) disable iff (!presetn)
      (!st_ff.g_dir[3] && !g_periph_out_en[3] && !g_periph_in_force[3])
      |=> (g_pin_oe[3] && g_pin_out[3] == $past(st_ff.g_lat[3])))
      else $error("Port G output pin not driving its latch.");
   a_master_clear_input_off: assert property (@(posedge pclk) disable iff (!presetn)
      !config_byte_three_high[7] |=> !master_clear_input)
      else $error("Master clear raised while disabled.");

endmodule : gph_ports
